// ===== core/acgp_defs.svh
`ifndef ACGP_DEFS_SVH
`define ACGP_DEFS_SVH

// Host address and data widths
`define ACGP_ADDR_W 12
`define ACGP_DATA_W 32

// Register offsets in the first base region
`define ACGP_OFS_JOY_BTN 12'h480
`define ACGP_OFS_JOY_PIN 12'h4A0
`define ACGP_OFS_EE_CTL 12'h4B0
`define ACGP_OFS_GEN_PIN 12'h4B8
`define ACGP_OFS_EXT_DIR 12'h4BC
`define ACGP_OFS_EXT_POL 12'h4C0
`define ACGP_OFS_EXT_LVL 12'h4D0

// General pin register fields
`define ACGP_GEN_VOL_DOWN_BIT 0
`define ACGP_GEN_VOL_UP_BIT 1
`define ACGP_GEN_AUXD_BIT 2
`define ACGP_GEN_AUXOE_BIT 3

// EEPROM control register fields
`define ACGP_EE_CLK_BIT 0
`define ACGP_EE_DOUT_BIT 1
`define ACGP_EE_EN_BIT 2
`define ACGP_EE_DIN_BIT 3

// Widths of pin groups
`define ACGP_EXT_N 9
`define ACGP_JOY_N 4
`define ACGP_SYNC_N 21

// Reset values
`define ACGP_RST_GEN_PIN 32'h0000_0000
`define ACGP_RST_AUX_D 1'b0
`define ACGP_RST_AUX_OE 1'b0
`define ACGP_RST_EXT_DIR 9'h000
`define ACGP_RST_EXT_POL 9'h1FF
`define ACGP_RST_EXT_LVL 9'h000
`define ACGP_RST_JOY_PIN 4'hF
`define ACGP_RST_EE_CTL 3'h2

// Synchroniser depth in flip-flops
`define ACGP_SYNC_STAGES 2

`endif

// ===== core/acgp_pkg.sv
package acgp_pkg;

    // Host register access request
    typedef struct packed {
        logic [11:0] addr;
        logic wr;
        logic rd;
        logic [31:0] wdata;
    } acgp_host_req_t;

    // Host register read answer
    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
    } acgp_host_rsp_t;

    // One tri-state pin group as seen by the core
    typedef struct packed {
        logic [8:0] out;
        logic [8:0] oe_n;
    } acgp_ext_drive_t;

    // Register select decoded from the address
    typedef enum logic [2:0] {
        ACGP_SEL_NONE,
        ACGP_SEL_JOY_BTN,
        ACGP_SEL_JOY_PIN,
        ACGP_SEL_EE_CTL,
        ACGP_SEL_GEN_PIN,
        ACGP_SEL_EXT_DIR,
        ACGP_SEL_EXT_POL,
        ACGP_SEL_EXT_LVL
    } acgp_sel_t;

endpackage

// ===== core/acgp_sync.sv
`timescale 1ns/10ps
`include "acgp_defs.svh"

// Two-flop synchroniser for a group of pin levels
module acgp_sync #(
    parameter int WIDTH = `ACGP_SYNC_N
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // One flop pair per bit; the first flop feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                end else begin
                    meta_reg[gi] <= async_in[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    assign sync_out = sync_reg;

endmodule

// ===== core/acgp_gpio_port.sv
// Summary of operation
// - Bit 0 of general pin register reads live volume-down level; writes ignored.
// - Bit 1 of general pin register reads live volume-up level; read only.
// - Aux pin value bit reads pin level; written value drives pin when enabled.
// - Aux pin output enable gates the driver; resets to 0, input only.
// - General pin register lives at 0x4B8, read-write, resets to zero.
// - Polarity/type register at 0x4C0 holds nine bits, reset 0x1FF.
// - Joystick coordinate pins are open-drain general pins at 0x4A0 unless joystick used.
// - Joystick buttons read at 0x480 only when joystick and aux serial unused.
// - Aux serial input pin is general only when aux serial input unused.
// - Volume inputs share crystal pins; general only when no crystal used.
// - EEPROM clock and data are general pins at 0x4B0; host keeps protocol.
// - Extended pins 3-6 carry async serial port, pin 8 carries clock-run.
// - Extended pins exist only on the 128-pin package; else no pin effect.
// - Polarity bit: input 0 active low, 1 active high; output 0 CMOS, 1 open drain.
`timescale 1ns/10ps
`include "acgp_defs.svh"

module acgp_gpio_port
    import acgp_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Host register port
    input wire acgp_host_req_t host_req_in,
    output acgp_host_rsp_t host_rsp_out,
    // System configuration levels
    input wire logic package_128_in,
    input wire logic crystal_in_use_in,
    input wire logic joystick_in_use_in,
    input wire logic [3:0] joystick_button_aux_use_in,
    input wire logic aux_serial_in_use_in,
    input wire logic aux_serial_oe_n_in,
    input wire logic aux_serial_out_in,
    input wire logic eeprom_engine_active_in,
    input wire logic eeprom_engine_clock_in,
    input wire logic eeprom_engine_data_oe_n_in,
    input wire logic async_serial_enable_in,
    input wire logic clkrun_enable_in,
    input wire logic [8:0] ext_alt_out_in,
    input wire logic [8:0] ext_alt_oe_n_in,
    // Pins
    input wire logic volume_down_sense_in,
    input wire logic volume_up_sense_in,
    input wire logic aux_serial_input_pin_in,
    output logic aux_serial_input_pin_out,
    output logic aux_serial_input_pin_oe_n_out,
    input wire logic [3:0] joystick_coord_pin_in,
    output logic [3:0] joystick_coord_pin_out,
    output logic [3:0] joystick_coord_pin_oe_n_out,
    input wire logic [3:0] joystick_button_pin_in,
    output logic eeprom_clock_pin_out,
    input wire logic eeprom_data_pin_in,
    output logic eeprom_data_pin_out,
    output logic eeprom_data_pin_oe_n_out,
    input wire logic [8:0] extended_pin_in,
    output logic [8:0] extended_pin_out,
    output logic [8:0] extended_pin_oe_n_out,
    // Pin data seen by alternate functions
    output logic [8:0] extended_pin_level_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_meta_reg;
    logic rst_n_reg;

    // Assert at once, release through two flops
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Package strap, caught after reset release

    logic strap_done_reg;
    logic pkg128_reg;

    // Sample the package strap once on the first clock out of reset
    always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            strap_done_reg <= 1'b0;
            pkg128_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            pkg128_reg <= package_128_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [20:0] raw_pins;
    logic [20:0] sync_pins;
    logic sy_vol_down;
    logic sy_vol_up;
    logic sy_aux;
    logic [3:0] sy_joy;
    logic [3:0] sy_btn;
    logic sy_eeprom_data_pin;
    logic [8:0] sy_ext;

    assign raw_pins = {extended_pin_in, eeprom_data_pin_in, joystick_button_pin_in,
                       joystick_coord_pin_in, aux_serial_input_pin_in,
                       volume_up_sense_in, volume_down_sense_in};

    acgp_sync #(
        .WIDTH(`ACGP_SYNC_N)
    ) u_sync (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n_reg),
        .async_in(raw_pins),
        .sync_out(sync_pins)
    );

    assign sy_vol_down = sync_pins[0];
    assign sy_vol_up = sync_pins[1];
    assign sy_aux = sync_pins[2];
    assign sy_joy = sync_pins[6:3];
    assign sy_btn = sync_pins[10:7];
    assign sy_eeprom_data_pin = sync_pins[11];
    assign sy_ext = sync_pins[20:12];

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    // Map a host offset to a register select
    function automatic acgp_sel_t decode_sel(input logic [11:0] addr);
        case (addr)
            `ACGP_OFS_JOY_BTN: decode_sel = ACGP_SEL_JOY_BTN;
            `ACGP_OFS_JOY_PIN: decode_sel = ACGP_SEL_JOY_PIN;
            `ACGP_OFS_EE_CTL: decode_sel = ACGP_SEL_EE_CTL;
            `ACGP_OFS_GEN_PIN: decode_sel = ACGP_SEL_GEN_PIN;
            `ACGP_OFS_EXT_DIR: decode_sel = ACGP_SEL_EXT_DIR;
            `ACGP_OFS_EXT_POL: decode_sel = ACGP_SEL_EXT_POL;
            `ACGP_OFS_EXT_LVL: decode_sel = ACGP_SEL_EXT_LVL;
            default: decode_sel = ACGP_SEL_NONE;
        endcase
    endfunction

    acgp_sel_t sel;
    logic wr_gen;
    logic wr_dir;
    logic wr_pol;
    logic wr_lvl;
    logic wr_joy;
    logic wr_ee;

    assign sel = decode_sel(host_req_in.addr);
    assign wr_gen = host_req_in.wr && (sel == ACGP_SEL_GEN_PIN);
    assign wr_dir = host_req_in.wr && (sel == ACGP_SEL_EXT_DIR);
    assign wr_pol = host_req_in.wr && (sel == ACGP_SEL_EXT_POL);
    assign wr_lvl = host_req_in.wr && (sel == ACGP_SEL_EXT_LVL);
    assign wr_joy = host_req_in.wr && (sel == ACGP_SEL_JOY_PIN);
    assign wr_ee = host_req_in.wr && (sel == ACGP_SEL_EE_CTL);

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    logic aux_d_reg;
    logic aux_oe_reg;
    logic [8:0] ext_dir_reg;
    logic [8:0] ext_pol_reg;
    logic [8:0] ext_lvl_reg;
    logic [3:0] joy_out_reg;
    logic [2:0] ee_ctl_reg;

    // general register writes, sense bits not stored
    always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            aux_d_reg <= `ACGP_RST_AUX_D;
            aux_oe_reg <= `ACGP_RST_AUX_OE;
        end else if (wr_gen) begin
            aux_d_reg <= host_req_in.wdata[`ACGP_GEN_AUXD_BIT];
            aux_oe_reg <= host_req_in.wdata[`ACGP_GEN_AUXOE_BIT];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ext_dir_reg <= `ACGP_RST_EXT_DIR;
            ext_pol_reg <= `ACGP_RST_EXT_POL;
            ext_lvl_reg <= `ACGP_RST_EXT_LVL;
        end else begin
            if (wr_dir) begin
                ext_dir_reg <= host_req_in.wdata[8:0];
            end
            if (wr_pol) begin
                ext_pol_reg <= host_req_in.wdata[8:0];
            end
            if (wr_lvl) begin
                ext_lvl_reg <= host_req_in.wdata[8:0];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            joy_out_reg <= `ACGP_RST_JOY_PIN;
            ee_ctl_reg <= `ACGP_RST_EE_CTL;
        end else begin
            if (wr_joy) begin
                joy_out_reg <= host_req_in.wdata[3:0];
            end
            if (wr_ee) begin
                ee_ctl_reg <= host_req_in.wdata[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auxiliary serial input pin

    // serial port owns the driver when it is in use
    assign aux_serial_input_pin_out = aux_serial_in_use_in ? aux_serial_out_in : aux_d_reg;
    // written value reaches pin only while enabled
    assign aux_serial_input_pin_oe_n_out = aux_serial_in_use_in ? aux_serial_oe_n_in
                                                                : ~aux_oe_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Joystick coordinate pins, open drain

    // pull low only for a written zero while joystick unused
    assign joystick_coord_pin_out = 4'h0;
    assign joystick_coord_pin_oe_n_out = joystick_in_use_in ? 4'hF : joy_out_reg;

    ////////////////////////////////////////////////////////////////////////////
    // EEPROM pins

    logic ee_host_own;

    // load engine owns pins while active; host keeps protocol
    assign ee_host_own = ~eeprom_engine_active_in;
    assign eeprom_clock_pin_out = ee_host_own ? ee_ctl_reg[`ACGP_EE_CLK_BIT]
                                              : eeprom_engine_clock_in;
    assign eeprom_data_pin_out = 1'b0;
    assign eeprom_data_pin_oe_n_out = ee_host_own
        ? ~(ee_ctl_reg[`ACGP_EE_EN_BIT] & ~ee_ctl_reg[`ACGP_EE_DOUT_BIT])
        : eeprom_engine_data_oe_n_in;

    ////////////////////////////////////////////////////////////////////////////
    // Extended pins

    logic [8:0] ext_alt_own;
    acgp_ext_drive_t ext_gen;
    acgp_ext_drive_t ext_drv;

    // pins 3-6 serial port, pin 8 clock-run
    assign ext_alt_own = {clkrun_enable_in, 1'b0, {4{async_serial_enable_in}}, 3'b000};

    // CMOS drives value, open drain only pulls low
    assign ext_gen.out = ext_lvl_reg & ~ext_pol_reg;
    assign ext_gen.oe_n = ~(ext_dir_reg & ~(ext_pol_reg & ext_lvl_reg));

    // alternate function takes over shared pins
    assign ext_drv.out = (ext_alt_own & ext_alt_out_in) | (~ext_alt_own & ext_gen.out);
    assign ext_drv.oe_n = (ext_alt_own & ext_alt_oe_n_in) | (~ext_alt_own & ext_gen.oe_n);

    // no pin effect outside the large package
    assign extended_pin_out = pkg128_reg ? ext_drv.out : 9'h000;
    assign extended_pin_oe_n_out = pkg128_reg ? ext_drv.oe_n : 9'h1FF;
    assign extended_pin_level_out = sy_ext;

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    logic [8:0] ext_active;
    logic [31:0] rd_gen;
    logic [31:0] rd_mux;
    logic [3:0] btn_avail;

    // input polarity: bit 1 active high, bit 0 active low
    assign ext_active = pkg128_reg ? ~(sy_ext ^ ext_pol_reg) : 9'h000;

    // volume sense reads zero while crystal used
    assign rd_gen = {28'h0000000, aux_oe_reg, sy_aux,
                     sy_vol_up & ~crystal_in_use_in, sy_vol_down & ~crystal_in_use_in};

    // buttons masked when joystick or aux serial claims them
    assign btn_avail = joystick_in_use_in ? 4'h0 : ~joystick_button_aux_use_in;

    always_comb begin
        case (sel)
            ACGP_SEL_JOY_BTN: rd_mux = {28'h0000000, sy_btn & btn_avail};
            ACGP_SEL_JOY_PIN: rd_mux = {28'h0000000, joystick_in_use_in ? 4'h0 : sy_joy};
            ACGP_SEL_EE_CTL: rd_mux = {28'h0000000, sy_eeprom_data_pin, ee_ctl_reg};
            ACGP_SEL_GEN_PIN: rd_mux = rd_gen;
            ACGP_SEL_EXT_DIR: rd_mux = {23'h000000, ext_dir_reg};
            ACGP_SEL_EXT_POL: rd_mux = {23'h000000, ext_pol_reg};
            ACGP_SEL_EXT_LVL: rd_mux = {23'h000000, ext_active};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read answer registered one cycle after the strobe
    always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            host_rsp_out <= '0;
        end else begin
            host_rsp_out.valid <= host_req_in.rd;
            host_rsp_out.rdata <= host_req_in.rd ? rd_mux : 32'h0000_0000;
        end
    end

endmodule

// ===== tb/acgp_gpio_port_assertions.sv
`timescale 1ns/10ps
module acgp_gpio_port_assertions
    import acgp_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire acgp_host_req_t host_req_in,
    input wire acgp_host_rsp_t host_rsp_out,
    input wire logic package_128_in,
    input wire logic crystal_in_use_in,
    input wire logic joystick_in_use_in,
    input wire logic aux_serial_in_use_in,
    input wire logic aux_serial_oe_n_in,
    input wire logic aux_serial_out_in,
    input wire logic async_serial_enable_in,
    input wire logic clkrun_enable_in,
    input wire logic [8:0] ext_alt_out_in,
    input wire logic [8:0] ext_alt_oe_n_in,
    input wire logic volume_down_sense_in,
    input wire logic volume_up_sense_in,
    input wire logic aux_serial_input_pin_out,
    input wire logic aux_serial_input_pin_oe_n_out,
    input wire logic [3:0] joystick_coord_pin_out,
    input wire logic [3:0] joystick_coord_pin_oe_n_out,
    input wire logic eeprom_data_pin_out,
    input wire logic [8:0] extended_pin_out,
    input wire logic [8:0] extended_pin_oe_n_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    // General pin register selected
    logic is_gen;
    assign is_gen = host_req_in.addr == 12'h4B8;

    // Volume and crystal levels quiet for four samples
    sequence s_vol_quiet;
        $stable({volume_up_sense_in, volume_down_sense_in, crystal_in_use_in})[*4];
    endsequence
    // General register written while the aux serial port is idle
    sequence s_gen_write;
        host_req_in.wr && is_gen && !aux_serial_in_use_in ##1 !aux_serial_in_use_in;
    endsequence

    chk_read_answer: assert property (host_req_in.rd |=> host_rsp_out.valid)
        else $error("read got no answer");
    chk_valid_only_read: assert property (!host_req_in.rd |=>
        !host_rsp_out.valid && host_rsp_out.rdata == 32'h0)
        else $error("answer without read");
    chk_volume_sense: assert property (s_vol_quiet ##0
        (host_req_in.rd && is_gen) |=>
        host_rsp_out.rdata[1:0] == ($past(crystal_in_use_in) ? 2'b00 :
        $past({volume_up_sense_in, volume_down_sense_in})))
        else $error("volume bits wrong");
    chk_aux_write: assert property (s_gen_write |->
        aux_serial_input_pin_oe_n_out == !$past(host_req_in.wdata[3]) &&
        (!$past(host_req_in.wdata[3]) || aux_serial_input_pin_out == $past(host_req_in.wdata[2])))
        else $error("aux pin drive wrong");
    chk_aux_alt_owns: assert property (aux_serial_in_use_in |->
        {aux_serial_input_pin_oe_n_out, aux_serial_input_pin_out} ==
        {aux_serial_oe_n_in, aux_serial_out_in})
        else $error("aux pin not owned by serial port");
    chk_ext_serial_alt: assert property (package_128_in && async_serial_enable_in |->
        extended_pin_oe_n_out[6:3] == ext_alt_oe_n_in[6:3] &&
        extended_pin_out[6:3] == ext_alt_out_in[6:3])
        else $error("serial port pins not owned");
    chk_clkrun_alt: assert property (package_128_in && clkrun_enable_in |->
        extended_pin_oe_n_out[8] == ext_alt_oe_n_in[8] && extended_pin_out[8] == ext_alt_out_in[8])
        else $error("clock-run pin not owned");
    chk_joy_open_drain: assert property (joystick_coord_pin_out == 4'h0 &&
        (!joystick_in_use_in || joystick_coord_pin_oe_n_out == 4'hF))
        else $error("joystick pin drive wrong");
    chk_ee_open_drain: assert property (eeprom_data_pin_out == 1'b0)
        else $error("eeprom data drives high");
endmodule

// ===== tb/acgp_board_model.sv
`timescale 1ns/10ps
module acgp_board_model (
    input wire logic ref_clk_in,
    input wire logic aux_en_in,
    input wire logic aux_in,
    input wire logic [8:0] ext_en_in,
    input wire logic [8:0] ext_in,
    input wire logic aux_out_in,
    input wire logic aux_oe_n_in,
    input wire logic [3:0] joy_oe_n_in,
    input wire logic ee_oe_n_in,
    input wire logic [8:0] ext_out_in,
    input wire logic [8:0] ext_oe_n_in,
    output logic aux_pin_out,
    output logic [3:0] joy_pin_out,
    output logic ee_pin_out,
    output logic [8:0] ext_pin_out
);
    logic flt = 1'b0;

    // Floating lines wander so a stale level never reads as good
    always @(posedge ref_clk_in) begin
        flt <= ~flt;
    end

    // Two-way lines: device driver first, then switch, else floating
    assign aux_pin_out = !aux_oe_n_in ? aux_out_in : (aux_en_in ? aux_in : flt);
    assign ext_pin_out = (~ext_oe_n_in & ext_out_in) | (ext_oe_n_in & ext_en_in & ext_in)
        | (ext_oe_n_in & ~ext_en_in & {9{flt}});
    assign joy_pin_out = joy_oe_n_in;
    assign ee_pin_out = ee_oe_n_in;
endmodule

// ===== tb/acgp_gpio_port_tb.sv
`timescale 1ns/10ps
bind acgp_gpio_port acgp_gpio_port_assertions i_chk (.*);

module acgp_gpio_port_tb;
    import acgp_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    acgp_host_req_t host_req_in = '0;
    acgp_host_rsp_t host_rsp_out;
    logic package_128_in = 1'b1;
    logic crystal_in_use_in = 1'b0;
    logic joystick_in_use_in = 1'b0;
    logic [3:0] joystick_button_aux_use_in = '0;
    logic aux_serial_in_use_in = 1'b0;
    logic aux_serial_oe_n_in = 1'b1;
    logic aux_serial_out_in = 1'b0;
    logic eeprom_engine_active_in = 1'b0;
    logic eeprom_engine_clock_in = 1'b0;
    logic eeprom_engine_data_oe_n_in = 1'b1;
    logic async_serial_enable_in = 1'b0;
    logic clkrun_enable_in = 1'b0;
    logic [8:0] ext_alt_out_in = '0;
    logic [8:0] ext_alt_oe_n_in = '1;
    logic volume_down_sense_in = 1'b0;
    logic volume_up_sense_in = 1'b0;
    logic [3:0] joystick_button_pin_in = '0;
    logic aux_serial_input_pin_in, aux_serial_input_pin_out, aux_serial_input_pin_oe_n_out;
    logic [3:0] joystick_coord_pin_in, joystick_coord_pin_out, joystick_coord_pin_oe_n_out;
    logic eeprom_clock_pin_out, eeprom_data_pin_in, eeprom_data_pin_out, eeprom_data_pin_oe_n_out;
    logic [8:0] extended_pin_in, extended_pin_out, extended_pin_oe_n_out, extended_pin_level_out;
    logic board_aux_en = 1'b1;
    logic board_aux = 1'b0;
    logic [8:0] board_ext_en = '0;
    logic [8:0] board_ext = '0;
    logic [31:0] r;
    logic [8:0] dir, pol, val, p;
    logic [17:0] e;
    logic [3:0] v;
    int fail_count = 0;
    int check_count = 0;

    acgp_gpio_port i_dut (.*);
    acgp_board_model i_board (.ref_clk_in(ref_clk_in), .aux_en_in(board_aux_en),
        .aux_in(board_aux), .ext_en_in(board_ext_en), .ext_in(board_ext),
        .aux_out_in(aux_serial_input_pin_out), .aux_oe_n_in(aux_serial_input_pin_oe_n_out),
        .joy_oe_n_in(joystick_coord_pin_oe_n_out), .ee_oe_n_in(eeprom_data_pin_oe_n_out),
        .ext_out_in(extended_pin_out), .ext_oe_n_in(extended_pin_oe_n_out),
        .aux_pin_out(aux_serial_input_pin_in), .joy_pin_out(joystick_coord_pin_in),
        .ee_pin_out(eeprom_data_pin_in), .ext_pin_out(extended_pin_in));

    ////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        #100000;
        fail_count++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge ref_clk_in);
        host_req_in = {a, 1'b1, 1'b0, d};
        @(negedge ref_clk_in);
        host_req_in = '0;
    endtask

    // Read with answer checked half a cycle after the taken edge
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        @(negedge ref_clk_in);
        host_req_in = {a, 1'b0, 1'b1, 32'h0};
        @(negedge ref_clk_in);
        host_req_in = '0;
        cmp({31'h0, host_rsp_out.valid}, 32'h1);
        cmp(host_rsp_out.rdata, exp);
    endtask

    // Expected extended drive: {oe_n, out}
    function automatic logic [17:0] ext_exp(input logic [8:0] d, input logic [8:0] t,
        input logic [8:0] x);
        logic [8:0] own;
        own = {clkrun_enable_in, 1'b0, {4{async_serial_enable_in}}, 3'b000};
        return {(own & ext_alt_oe_n_in) | (~own & (~d | (t & x))),
            (own & ext_alt_out_in) | (~own & x & ~t)};
    endfunction

    task automatic summarize();
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        r = $urandom(32);
        repeat (5) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        rstn_in = 1'b1;
        repeat (4) @(negedge ref_clk_in);
        rdc(12'h4B8, 32'h0);
        rdc(12'h4BC, 32'h0);
        rdc(12'h4C0, 32'h1FF);
        rdc(12'h004, 32'h0);
        cmp(aux_serial_input_pin_oe_n_out, 1'b1);
        // Volume sense with writes to read-only bits
        for (int i = 0; i < 8; i++) begin
            {volume_down_sense_in, volume_up_sense_in, crystal_in_use_in, board_aux} =
                4'($urandom);
            repeat (4) @(negedge ref_clk_in);
            wr(12'h4B8, 32'h3);
            v = crystal_in_use_in ? 4'h0 : {2'b00, volume_up_sense_in, volume_down_sense_in};
            rdc(12'h4B8, {29'h0, board_aux, v[1:0]});
        end
        // Aux pin driven by the host, then by the serial port
        board_aux_en = 1'b0;
        crystal_in_use_in = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(12'h4B8, {28'h0, 1'b1, i[0], 2'b00});
            repeat (3) @(negedge ref_clk_in);
            cmp({aux_serial_input_pin_oe_n_out, aux_serial_input_pin_out}, {1'b0, i[0]});
            rdc(12'h4B8, {28'h0, 1'b1, i[0], 2'b00});
        end
        {aux_serial_in_use_in, aux_serial_oe_n_in, aux_serial_out_in} = 3'b101;
        @(negedge ref_clk_in);
        cmp({aux_serial_input_pin_oe_n_out, aux_serial_input_pin_out}, 2'b01);
        aux_serial_in_use_in = 1'b0;
        wr(12'h4B8, 32'h0);
        // Extended pins: direction, polarity/type, alternate owners
        for (int i = 0; i < 12; i++) begin
            {dir, pol, val} = 27'($urandom);
            if (i == 0) {dir, pol} = {9'h1FF, 9'h000};
            {async_serial_enable_in, clkrun_enable_in} = 2'($urandom);
            {ext_alt_out_in, ext_alt_oe_n_in} = 18'($urandom);
            wr(12'h4BC, {23'h0, dir});
            wr(12'h4C0, {23'h0, pol});
            wr(12'h4D0, {23'h0, val});
            e = ext_exp(dir, pol, val);
            board_ext_en = e[17:9];
            board_ext = 9'($urandom);
            p = (~e[17:9] & e[8:0]) | (e[17:9] & board_ext);
            repeat (4) @(negedge ref_clk_in);
            r = {14'h0, extended_pin_oe_n_out, extended_pin_out & ~extended_pin_oe_n_out};
            cmp(r, {14'h0, e[17:9], e[8:0] & ~e[17:9]});
            cmp(extended_pin_level_out, p);
            rdc(12'h4BC, {23'h0, dir});
            rdc(12'h4C0, {23'h0, pol});
            rdc(12'h4D0, {23'h0, ~(p ^ pol)});
        end
        {async_serial_enable_in, clkrun_enable_in} = 2'b00;
        // Joystick coordinate and button pins
        for (int i = 0; i < 4; i++) begin
            v = 4'($urandom);
            joystick_in_use_in = (i == 3);
            {joystick_button_pin_in, joystick_button_aux_use_in} = 8'($urandom);
            wr(12'h4A0, {28'h0, v});
            repeat (4) @(negedge ref_clk_in);
            cmp(joystick_coord_pin_oe_n_out, joystick_in_use_in ? 4'hF : v);
            rdc(12'h4A0, joystick_in_use_in ? 32'h0 : {28'h0, v});
            v = joystick_button_pin_in & ~joystick_button_aux_use_in;
            rdc(12'h480, joystick_in_use_in ? 32'h0 : {28'h0, v});
        end
        // Host-owned EEPROM clock and data
        wr(12'h4B0, 32'h1);
        cmp(eeprom_clock_pin_out, 1'b1);
        wr(12'h4B0, 32'h4);
        cmp({eeprom_clock_pin_out, eeprom_data_pin_oe_n_out}, 2'b00);
        repeat (3) @(negedge ref_clk_in);
        rdc(12'h4B0, 32'h4);
        // Load engine takes the EEPROM pins over from the host
        {eeprom_engine_active_in, eeprom_engine_clock_in, eeprom_engine_data_oe_n_in} = 3'b111;
        @(negedge ref_clk_in);
        cmp({eeprom_clock_pin_out, eeprom_data_pin_oe_n_out}, 2'b11);
        eeprom_engine_active_in = 1'b0;
        // Smaller package: extended pins stay undriven
        package_128_in = 1'b0;
        rstn_in = 1'b0;
        repeat (2) @(negedge ref_clk_in);
        rstn_in = 1'b1;
        repeat (4) @(negedge ref_clk_in);
        wr(12'h4BC, 32'h1FF);
        wr(12'h4C0, 32'h0);
        cmp({extended_pin_oe_n_out, extended_pin_out}, {9'h1FF, 9'h000});
        rdc(12'h4D0, 32'h0);
        summarize();
    end
endmodule
